// ### design/skip_timer_ops.sv
// Skip tests and timer 1 load for the 4-bit core.
// How it works
// - Skip when memory bit j at pointer is zero.
// - Skip on carry zero; carry never altered.
// - Carry one: next instruction executes normally.
// - Two-word port test skips when D(Y) zero.
// - Register B loads timer 1, reload high nibbles.
// - Accumulator loads timer 1, reload low nibbles.
`timescale 1ns/100ps
module skip_timer_ops
	import skip_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic                mclk_i,
	input  wire logic                reset_i,
	// Instruction stream from the sequencer.
	input  wire logic                instr_valid_i,
	input  wire logic [INSTR_W-1:0]  instr_i,
	// Core state.
	input  wire logic [NIBBLE_W-1:0] mem_word_i,
	input  wire logic                carry_flag_i,
	input  wire logic [Y_W-1:0]      y_reg_i,
	input  wire logic [NIBBLE_W-1:0] acc_i,
	input  wire logic [NIBBLE_W-1:0] reg_b_i,
	// Port D pins.
	input  wire logic [PORT_D_BITS-1:0] port_d_i,
	// Sequencer answers.
	output logic                     skip_o,
	output logic                     busy_o,
	// Timer 1.
	output logic                     timer1_load_o,
	output logic [TIMER_W-1:0]       timer1_value_o,
	output logic [TIMER_W-1:0]       timer1_reload_reg_o
);
	logic [PORT_D_BITS-1:0] port_meta;
	logic [PORT_D_BITS-1:0] port_sync;
	seq_state_t             state;
	seq_state_t             next_state;
	logic                   next_skip;
	logic                   next_busy;
	logic                   next_load;
	logic [TIMER_W-1:0]     next_value;
	logic [TIMER_W-1:0]     next_reload;
	logic                   is_mem_bit;
	logic                   is_carry;
	logic                   is_port_w1;
	logic                   is_port_w2;
	logic                   is_t1_load;
	logic                   mem_bit;
	logic                   port_bit_ref;

	bit_pick_if pick ();

	bit_picker u_port_pick (
		.pick (pick.picker)
	);

	// Pins are synchronised before the selector reads them.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			port_meta <= PORT_RESET;
			port_sync <= PORT_RESET;
		end else begin
			port_meta <= port_d_i;
			port_sync <= port_meta;
		end
	end

	// Bits above the implemented port read as zero.
	assign pick.word = {{(PICK_W-PORT_D_BITS){1'b0}}, port_sync};
	assign pick.sel  = y_reg_i;

	// Y above the implemented port bits picks a padding zero, so the
	// test skips; software has to keep Y in range.
	assign port_bit_ref = (int'(y_reg_i) < PORT_D_BITS)
		&& port_sync[y_reg_i];

	always_comb begin
		is_mem_bit = instr_valid_i && ((instr_i & OP_MEM_MASK) == OP_MEM_BIT);
		is_carry   = instr_valid_i && (instr_i == OP_CARRY);
		is_port_w1 = instr_valid_i && (instr_i == OP_PORT_W1);
		is_port_w2 = instr_valid_i && (instr_i == OP_PORT_W2);
		is_t1_load = instr_valid_i && (instr_i == OP_T1_LOAD);
		mem_bit    = mem_word_i[instr_i[J_W-1:0]];
	end

	// Sequencing and skip decision.
	always_comb begin
		next_state = ST_IDLE;
		next_skip  = 1'b0;
		next_busy  = 1'b0;
		case (state)
			ST_IDLE: begin
				if (is_mem_bit) begin
					next_skip = ~mem_bit;
				end else if (is_carry) begin
					// Carry is only read here, never written.
					next_skip = ~carry_flag_i;
				end else if (is_port_w1) begin
					next_state = ST_PORT2;
					next_busy  = 1'b1;
				end
			end
			ST_PORT2: begin
				if (is_port_w2) begin
					next_skip = ~pick.bit_out;
				end else if (!instr_valid_i) begin
					// Wait for the second word to arrive.
					next_state = ST_PORT2;
					next_busy  = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state  <= ST_IDLE;
			skip_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			state  <= next_state;
			skip_o <= next_skip;
			busy_o <= next_busy;
		end
	end

	// Timer 1 and its reload register take the same byte in one cycle.
	always_comb begin
		next_load   = 1'b0;
		next_value  = timer1_value_o;
		next_reload = timer1_reload_reg_o;
		// A load word that arrives during a port test only ends that test.
		if (is_t1_load && state == ST_IDLE) begin
			next_load   = 1'b1;
			next_value  = {reg_b_i, acc_i};
			next_reload = {reg_b_i, acc_i};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			timer1_load_o       <= 1'b0;
			timer1_value_o      <= TIMER_RESET;
			timer1_reload_reg_o <= RELOAD_RESET;
		end else begin
			timer1_load_o       <= next_load;
			timer1_value_o      <= next_value;
			timer1_reload_reg_o <= next_reload;
		end
	end

	// Every answer lands one edge after the word that asks for it.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	a_mem_bit_skip: assert property (
		(state == ST_IDLE && is_mem_bit)
		|=> skip_o == !$past(mem_bit))
	else $error("memory bit skip wrong");

	a_carry_zero_skip: assert property (
		(state == ST_IDLE && is_carry && !carry_flag_i) |=> skip_o)
	else $error("carry zero did not skip");

	a_carry_one_runs: assert property (
		(state == ST_IDLE && is_carry && carry_flag_i) |=> !skip_o)
	else $error("carry one skipped");

	a_port_two_cycle: assert property (
		(state == ST_IDLE && is_port_w1) |=> busy_o ##0 !skip_o)
	else $error("port test first word wrong");

	a_port_bit_skip: assert property (
		(state == ST_PORT2 && is_port_w2)
		|=> skip_o == !$past(port_bit_ref) ##0 !busy_o)
	else $error("port bit skip wrong");

	a_timer_high_b: assert property (
		(state == ST_IDLE && is_t1_load) |=> timer1_load_o
		&& timer1_value_o[7:4] == $past(reg_b_i)
		&& timer1_reload_reg_o[7:4] == $past(reg_b_i))
	else $error("timer high nibble wrong");

	a_timer_low_acc: assert property (
		(state == ST_IDLE && is_t1_load)
		|=> timer1_value_o[3:0] == $past(acc_i)
		&& timer1_reload_reg_o[3:0] == $past(acc_i))
	else $error("timer low nibble wrong");

	a_reload_holds: assert property (
		!timer1_load_o |-> $stable(timer1_reload_reg_o) or $past(reset_i))
	else $error("reload changed without load");

	a_skip_single: assert property (
		skip_o |=> !skip_o || $past(instr_valid_i))
	else $error("skip without cause");

	a_port_waits: assert property (
		(state == ST_PORT2 && !instr_valid_i) |=> busy_o && !skip_o)
	else $error("port test did not wait");

	a_port_abort: assert property (
		(state == ST_PORT2 && instr_valid_i && !is_port_w2)
		|=> !busy_o && !skip_o && !timer1_load_o)
	else $error("aborted port test still acted");

	a_value_holds: assert property (
		!timer1_load_o |-> $stable(timer1_value_o) or $past(reset_i))
	else $error("timer value changed without load");

	a_idle_quiet: assert property (
		(state == ST_IDLE && !instr_valid_i)
		|=> !skip_o && !busy_o && !timer1_load_o)
	else $error("answer without a word");

	c_mem_skip: cover property (is_mem_bit ##1 skip_o);
	c_port_abort: cover property (
		state == ST_PORT2 && instr_valid_i && !is_port_w2);
	c_carry_run: cover property (is_carry && carry_flag_i);
	c_port_skip: cover property (is_port_w1 ##1 is_port_w2 ##1 skip_o);
	c_timer_load: cover property (timer1_load_o);
endmodule : skip_timer_ops

// ### design/skip_timer_pkg.sv
// Constants and types for the skip test and timer 1 load logic.
package skip_timer_pkg;
	localparam int          INSTR_W      = 10;
	localparam int          NIBBLE_W     = 4;
	localparam int          TIMER_W      = 8;
	localparam int          PORT_D_BITS  = 6;
	localparam int          Y_W          = 3;
	localparam int          PICK_W       = 8;
	localparam int          J_W          = 2;
	// Opcodes; the memory-bit test carries its index in the two low bits.
	localparam logic [9:0]  OP_MEM_BIT   = 10'h020;
	localparam logic [9:0]  OP_MEM_MASK  = 10'h3fc;
	localparam logic [9:0]  OP_CARRY     = 10'h02f;
	localparam logic [9:0]  OP_PORT_W1   = 10'h024;
	localparam logic [9:0]  OP_PORT_W2   = 10'h02b;
	localparam logic [9:0]  OP_T1_LOAD   = 10'h230;
	localparam logic [7:0]  TIMER_RESET  = 8'h00;
	localparam logic [7:0]  RELOAD_RESET = 8'h00;
	localparam logic [5:0]  PORT_RESET   = 6'h00;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_PORT2 = 1'b1
	} seq_state_t;
endpackage : skip_timer_pkg

// ### design/bit_pick_if.sv
// Carrier between the main logic and the bit selector.
`timescale 1ns/100ps
interface bit_pick_if;
	import skip_timer_pkg::*;
	logic [PICK_W-1:0] word;
	logic [Y_W-1:0]    sel;
	logic              bit_out;
	modport chooser (output word, output sel, input bit_out);
	modport picker  (input word, input sel, output bit_out);
endinterface : bit_pick_if

// ### design/bit_picker.sv
// Selects one bit of a word by an index.
`timescale 1ns/100ps
module bit_picker
	import skip_timer_pkg::*;
(
	bit_pick_if.picker pick
);
	assign pick.bit_out = pick.word[pick.sel];
endmodule : bit_picker

// ### tb/skip_timer_ops_tb_top.sv
// Self-checking bench for the skip tests and timer 1 load logic.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
	n_errors++; $display("BAD %0t mismatch", $time); end end
module skip_timer_ops_tb_top;
	import skip_timer_pkg::*;
	logic                    mclk_i = 1'b0;
	logic                    reset_i = 1'b1;
	logic                    instr_valid_i = 1'b0;
	logic [INSTR_W-1:0]      instr_i = 10'h000;
	logic [NIBBLE_W-1:0]     mem_word_i = 4'h0;
	logic                    carry_flag_i = 1'b0;
	logic [Y_W-1:0]          y_reg_i = 3'h0;
	logic [NIBBLE_W-1:0]     acc_i = 4'h0;
	logic [NIBBLE_W-1:0]     reg_b_i = 4'h0;
	logic [PORT_D_BITS-1:0]  port_d_i = 6'h00;
	logic                    skip_o;
	logic                    busy_o;
	logic                    timer1_load_o;
	logic [TIMER_W-1:0]      timer1_value_o;
	logic [TIMER_W-1:0]      timer1_reload_reg_o;
	int                      n_errors = 0;
	int                      checks = 0;
	int                      cycles = 0;

	skip_timer_ops i_dut (.mclk_i(mclk_i), .reset_i(reset_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.mem_word_i(mem_word_i), .carry_flag_i(carry_flag_i),
		.y_reg_i(y_reg_i), .acc_i(acc_i), .reg_b_i(reg_b_i),
		.port_d_i(port_d_i), .skip_o(skip_o), .busy_o(busy_o),
		.timer1_load_o(timer1_load_o), .timer1_value_o(timer1_value_o),
		.timer1_reload_reg_o(timer1_reload_reg_o));

	always #4 mclk_i = ~mclk_i;

	task automatic conclude;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	// The hang guard counts as a mismatch before closing.
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles >= 2000) begin
			n_errors++;
			conclude();
		end
	end

	// Called just after a rising edge; returns at the falling edge after
	// the edge that takes the word, while the answer stands.
	task automatic issue(input logic [INSTR_W-1:0] op);
		instr_valid_i <= 1'b1;
		instr_i       <= op;
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		@(negedge mclk_i);
	endtask : issue

	task automatic test_mem_bit;
		for (int j = 0; j < 4; j++) begin
			@(posedge mclk_i);
			mem_word_i <= ~(4'h1 << j);
			issue(OP_MEM_BIT | 10'(j));
			`CHK(skip_o, 1'b1)
			@(posedge mclk_i);
			mem_word_i <= 4'h1 << j;
			issue(OP_MEM_BIT | 10'(j));
			`CHK(skip_o, 1'b0)
		end
		$display("mem bit test done");
	endtask : test_mem_bit

	task automatic test_carry;
		@(posedge mclk_i);
		carry_flag_i <= 1'b0;
		issue(OP_CARRY);
		`CHK(skip_o, 1'b1)
		@(posedge mclk_i);
		carry_flag_i <= 1'b1;
		issue(OP_CARRY);
		`CHK(skip_o, 1'b0)
		$display("carry test done");
	endtask : test_carry

	// Two-word port test; the pins settle well before the first word.
	task automatic port_test(input logic [2:0] y, input logic [5:0] pins);
		@(posedge mclk_i);
		port_d_i <= pins;
		repeat (3) @(posedge mclk_i);
		instr_valid_i <= 1'b1;
		instr_i       <= OP_PORT_W1;
		@(posedge mclk_i);
		instr_i <= OP_PORT_W2;
		y_reg_i <= y;
		#1;
		`CHK(busy_o, 1'b1)
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		#1;
		`CHK(skip_o, ~pins[y])
		`CHK(busy_o, 1'b0)
	endtask : port_test

	task automatic test_port;
		for (int y = 0; y < PORT_D_BITS; y++) begin
			port_test(3'(y), 6'h3f ^ (6'h01 << y));
			port_test(3'(y), 6'h01 << y);
		end
		$display("port test done");
	endtask : test_port

	// The port test waits through idle cycles; any other word ends it.
	task automatic test_port_order;
		@(posedge mclk_i);
		port_d_i     <= 6'h3b;
		y_reg_i      <= 3'h2;
		carry_flag_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		issue(OP_PORT_W1);
		`CHK(busy_o, 1'b1)
		@(negedge mclk_i);
		`CHK(busy_o, 1'b1)
		@(posedge mclk_i);
		issue(OP_PORT_W2);
		`CHK(skip_o, 1'b1)
		`CHK(busy_o, 1'b0)
		@(posedge mclk_i);
		issue(OP_PORT_W1);
		@(posedge mclk_i);
		issue(OP_CARRY);
		`CHK(skip_o, 1'b0)
		`CHK(busy_o, 1'b0)
		$display("port order test done");
	endtask : test_port_order

	task automatic test_timer;
		@(posedge mclk_i);
		acc_i   <= 4'h5;
		reg_b_i <= 4'ha;
		issue(OP_T1_LOAD);
		`CHK(timer1_load_o, 1'b1)
		`CHK(timer1_value_o, 8'ha5)
		`CHK(timer1_reload_reg_o, 8'ha5)
		@(posedge mclk_i);
		acc_i   <= 4'hc;
		reg_b_i <= 4'h3;
		issue(OP_T1_LOAD);
		`CHK(timer1_load_o, 1'b1)
		`CHK(timer1_value_o, 8'h3c)
		`CHK(timer1_reload_reg_o, 8'h3c)
		@(negedge mclk_i);
		`CHK(timer1_load_o, 1'b0)
		`CHK(timer1_reload_reg_o, 8'h3c)
		$display("timer test done");
	endtask : test_timer

	// A reset in the middle of a port test clears busy and both timer registers.
	task automatic test_reset;
		@(posedge mclk_i);
		issue(OP_PORT_W1);
		`CHK(busy_o, 1'b1)
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(negedge mclk_i);
		`CHK(busy_o, 1'b0)
		`CHK(timer1_value_o, TIMER_RESET)
		`CHK(timer1_reload_reg_o, RELOAD_RESET)
		@(posedge mclk_i);
		carry_flag_i <= 1'b0;
		issue(OP_CARRY);
		`CHK(skip_o, 1'b1)
		$display("reset test done");
	endtask : test_reset

	initial begin
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		test_mem_bit();
		test_carry();
		test_port();
		test_port_order();
		test_timer();
		test_reset();
		conclude();
	end
endmodule : skip_timer_ops_tb_top
